// *** core/ifs_map.svh ***
/*
 * Constants of the flash-backed serial slave: reset values, address codes
 * and default build choices.
 * Assumes it is included by the package and by the slave core only.
 */
`ifndef IFS_MAP_SVH
`define IFS_MAP_SVH

// ****************************************************************
// Address codes
// ****************************************************************
`define IFS_ADDR_HIGH_RST 4'hA
`define IFS_FULL_ERASE_SEL 3'h7
`define IFS_PTR_RST 10'h000

// ****************************************************************
// Build defaults
// ****************************************************************
`define IFS_MEM_BYTES_DEF 512
`define IFS_PAGE_BYTES_DEF 16
`define IFS_TRIG0_DEF 0

`endif

// *** core/ifs_pkg.sv ***
/*
 * Types shared by the flash-backed serial slave.
 * Assumes ifs_map.svh sits beside it in core/.
 */
`default_nettype none
`include "ifs_map.svh"

package ifs_pkg;

    // ****************************************************************
    // Enumerations
    // ****************************************************************
    typedef enum logic [1:0] {
        IFS_ER_FULL = 2'b00,
        IFS_ER_TRIG = 2'b01,
        IFS_ER_BIT2 = 2'b10,
        IFS_ER_NONE = 2'b11
    } ifs_erase_t;

    typedef enum logic [2:0] {
        IFS_ST_IDLE = 3'b000,
        IFS_ST_RX = 3'b001,
        IFS_ST_ACK = 3'b010,
        IFS_ST_TX = 3'b011,
        IFS_ST_TXACK = 3'b100
    } ifs_bus_t;

    typedef enum logic [1:0] {
        IFS_PH_DEV = 2'b00,
        IFS_PH_ADDR = 2'b01,
        IFS_PH_DATA = 2'b10
    } ifs_phase_t;

    typedef enum logic [2:0] {
        IFS_SQ_IDLE = 3'b000,
        IFS_SQ_ERASE = 3'b001,
        IFS_SQ_EWAIT = 3'b010,
        IFS_SQ_PROG = 3'b011,
        IFS_SQ_PWAIT = 3'b100
    } ifs_seq_t;

endpackage

`default_nettype wire

// *** core/ifs_sync.sv ***
/*
 * Two-flop synchronisers for pins that arrive from outside mclk.
 * Assumes static reset values are wanted for each bit.
 */
`default_nettype none

module ifs_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Pins
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ****************************************************************
    // Per-bit chain
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic meta_r;
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_r <= RST_VAL[gi];
                    sync_out[gi] <= RST_VAL[gi];
                end else begin
                    meta_r <= async_in[gi];
                    sync_out[gi] <= meta_r;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// *** core/ifs_slave.sv ***
/*
 * Serial two-wire slave that fronts the on-chip user flash array like a
 * byte-wide EEPROM: page writes, deferred program and erase, polling.
 * Assumes the flash port answers each command with one done pulse on mclk
 * and returns read data in the cycle after a read strobe.
 */
`default_nettype none
`include "ifs_map.svh"

// Function
// - A page write accepts up to PAGE_BYTES data bytes, 8, 16 or 32.
// - Programming starts only at the stop condition that ends the write.
// - While busy the slave address is not acknowledged.
// - Protect pin high refuses write and erase in the protected region.
// - Protected write acks address bytes, nacks first data byte.
// - Only sector or full erase exist; read-only build has none.
// - Exactly one erase method is chosen at build time.
// - Address with select bits 111 selects full erase in full mode.
// - Full erase starts at stop and acknowledges stay off meanwhile.
// - Protected full-erase address is not acknowledged, nothing erased.
// - Write to a sector trigger address erases that sector, then programs.
// - Trigger defaults are 0 and half memory; completion by polling.
// - Select bit two high means sector erase; bits one, zero still match unless used as address bits.
// - At 512 bytes in bit-two mode select bit zero is address bit 8.
// - Erase byte address names the sector; erase runs after stop.
// - Protected sector erase nacks the byte address and skips erase.
// - No-erase build never erases and carries no erase logic.
// - Direction bit one reads; pointer increments after each byte sent.
// - Random read is a dummy write, repeated start, then read.
// - Sequential read continues while master acks, ends on its nack.
// - Address is four programmable bits, three select pins, direction.
// - Memory sizes 128, 256, 512 or 1024 bytes.
module ifs_slave
    import ifs_pkg::*;
#(
    parameter int MEM_BYTES = `IFS_MEM_BYTES_DEF,
    parameter int PAGE_BYTES = `IFS_PAGE_BYTES_DEF,
    parameter ifs_erase_t ERASE_MODE = IFS_ER_FULL,
    parameter bit READ_ONLY = 1'b0,
    parameter bit WP_FULL = 1'b0,
    parameter logic [3:0] ADDR_HIGH = `IFS_ADDR_HIGH_RST,
    parameter int TRIG0 = `IFS_TRIG0_DEF,
    parameter int TRIG1 = MEM_BYTES / 2
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Serial bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // Strap and protect pins
    input wire logic write_protect,
    input wire logic device_select_bit_two,
    input wire logic device_select_bit_one,
    input wire logic device_select_bit_zero,
    // User flash array port
    output logic [9:0] flash_addr,
    output logic [7:0] flash_wdata,
    output logic flash_rd,
    output logic flash_prog,
    output logic flash_erase,
    output logic flash_erase_all,
    output logic flash_sector,
    input wire logic [7:0] flash_rdata,
    input wire logic flash_done,
    // Status
    output logic busy
);

    localparam int AW = $clog2(MEM_BYTES);
    localparam int CW = $clog2(PAGE_BYTES) + 1;
    localparam logic [2:0] SEL_MASK = (AW == 10) ? 3'b011 : (AW == 9) ? 3'b001 : 3'b000;
    localparam logic [2:0] CMP_MASK = ~SEL_MASK & ((ERASE_MODE == IFS_ER_BIT2) ? 3'b011 : 3'b111);

    // ****************************************************************
    // Build checks
    // ****************************************************************
    generate
        if (!(MEM_BYTES inside {128, 256, 512, 1024})) begin : g_bad_mem
            $error("Memory size must be 128, 256, 512 or 1024 bytes.");
        end
        if (PAGE_BYTES != 8 && PAGE_BYTES != 16 && PAGE_BYTES != 32) begin : g_bad_page
            $error("Page size must be 8, 16 or 32 bytes.");
        end
        if (READ_ONLY && ERASE_MODE != IFS_ER_NONE) begin : g_bad_ro
            $error("A read-only build must use the no-erase method.");
        end
    endgenerate

    // ****************************************************************
    // Pin synchronisers and bus conditions
    // ****************************************************************
    logic [5:0] pins_s;
    logic scl_s, sda_s, wp_s, scl_q, sda_q;
    logic [2:0] sel_s;

    ifs_sync #(.WIDTH(6), .RST_VAL(6'h3F)) u_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .async_in({scl_i, sda_i, write_protect, device_select_bit_two,
                   device_select_bit_one, device_select_bit_zero}),
        .sync_out(pins_s)
    );

    assign {scl_s, sda_s, wp_s, sel_s} = pins_s;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_c = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_c = scl_s & scl_q & ~sda_q & sda_s;

    // ****************************************************************
    // Byte decode
    // ****************************************************************
    ifs_bus_t st_r;
    ifs_phase_t ph_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] sh_r, tx_r;
    logic sda_low_r, rw_r, er_sel_r, er_go_r, all_r, trig_r, refused_r, busy_r;
    logic [1:0] hi_r;
    logic [AW-1:0] ptr_r, base_r;
    logic [CW-1:0] cnt_r;

    logic byte_end, dev_ev, addr_ev, data_ev, tx_done;
    logic hi_ok, own_ok, full_ok, sec_ok, dev_ack, addr_ack, data_ack;
    logic [2:0] rx_sel;
    logic [9:0] addr_full;
    logic [AW-1:0] addr_c;
    logic prot_addr, prot_ptr, dev_rd_ev, launch;

    assign byte_end = (st_r == IFS_ST_RX) && scl_fall && (bit_cnt_r == 4'h8);
    assign dev_ev = byte_end && (ph_r == IFS_PH_DEV);
    assign addr_ev = byte_end && (ph_r == IFS_PH_ADDR);
    assign data_ev = byte_end && (ph_r == IFS_PH_DATA);
    assign tx_done = (st_r == IFS_ST_TX) && scl_fall && (bit_cnt_r == 4'h8);

    assign rx_sel = sh_r[3:1];
    assign hi_ok = (sh_r[7:4] == ADDR_HIGH);
    assign own_ok = hi_ok && (((rx_sel ^ sel_s) & CMP_MASK) == 3'h0)
                    && !((ERASE_MODE == IFS_ER_BIT2) && rx_sel[2]);
    assign full_ok = (ERASE_MODE == IFS_ER_FULL) && hi_ok && !own_ok && !sh_r[0]
                     && (rx_sel == `IFS_FULL_ERASE_SEL);
    assign sec_ok = (ERASE_MODE == IFS_ER_BIT2) && hi_ok && rx_sel[2] && !sh_r[0]
                    && (((rx_sel ^ sel_s) & CMP_MASK) == 3'h0);
    assign dev_ack = !busy_r && (own_ok || sec_ok || (full_ok && !wp_s));

    assign addr_full = {hi_r, sh_r};
    assign addr_c = addr_full[AW-1:0];
    assign prot_addr = wp_s && (WP_FULL || addr_c[AW-1]);
    assign prot_ptr = wp_s && (WP_FULL || ptr_r[AW-1]);
    assign addr_ack = !(er_sel_r && prot_addr);
    assign data_ack = !READ_ONLY && !er_sel_r && !refused_r
                      && (cnt_r != CW'(PAGE_BYTES))
                      && !((cnt_r == '0) && prot_ptr);
    assign dev_rd_ev = dev_ev && dev_ack && sh_r[0];
    assign launch = stop_c && !busy_r && (er_go_r || (cnt_r != '0));

    // ****************************************************************
    // Bus state machine
    // ****************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= IFS_ST_IDLE;
            ph_r <= IFS_PH_DEV;
            bit_cnt_r <= 4'h0;
            sh_r <= 8'h00;
            sda_low_r <= 1'b0;
        end else if (start_c) begin
            st_r <= IFS_ST_RX;
            ph_r <= IFS_PH_DEV;
            bit_cnt_r <= 4'h0;
            sda_low_r <= 1'b0;
        end else if (stop_c) begin
            st_r <= IFS_ST_IDLE;
            sda_low_r <= 1'b0;
        end else begin
            case (st_r)
                IFS_ST_RX: begin
                    if (scl_rise && bit_cnt_r != 4'h8) begin
                        sh_r <= {sh_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (byte_end) begin
                        case (ph_r)
                            IFS_PH_DEV: sda_low_r <= dev_ack;
                            IFS_PH_ADDR: sda_low_r <= addr_ack;
                            default: sda_low_r <= data_ack;
                        endcase
                        if ((ph_r == IFS_PH_DEV && dev_ack) || (ph_r == IFS_PH_ADDR && addr_ack)
                            || (ph_r == IFS_PH_DATA && data_ack)) begin
                            st_r <= IFS_ST_ACK;
                        end else begin
                            st_r <= IFS_ST_IDLE;
                        end
                    end
                end
                IFS_ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (rw_r && ph_r == IFS_PH_DEV) begin
                            st_r <= IFS_ST_TX;
                            sda_low_r <= ~tx_r[7];
                            sh_r <= {tx_r[6:0], 1'b0};
                            bit_cnt_r <= 4'h1;
                        end else begin
                            st_r <= IFS_ST_RX;
                            sda_low_r <= 1'b0;
                            ph_r <= (ph_r == IFS_PH_DEV) ? IFS_PH_ADDR : IFS_PH_DATA;
                        end
                    end
                end
                IFS_ST_TX: begin
                    if (tx_done) begin
                        st_r <= IFS_ST_TXACK;
                        sda_low_r <= 1'b0;
                    end else if (scl_fall) begin
                        sda_low_r <= ~sh_r[7];
                        sh_r <= {sh_r[6:0], 1'b0};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                end
                IFS_ST_TXACK: begin
                    if (scl_rise && sda_s) begin
                        st_r <= IFS_ST_IDLE;
                    end else if (scl_fall) begin
                        st_r <= IFS_ST_TX;
                        sda_low_r <= ~tx_r[7];
                        sh_r <= {tx_r[6:0], 1'b0};
                        bit_cnt_r <= 4'h1;
                    end
                end
                default: begin
                    sda_low_r <= 1'b0;
                end
            endcase
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_n = ~sda_low_r;

    // ****************************************************************
    // Address pointer
    // ****************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ptr_r <= AW'(`IFS_PTR_RST);
        end else if (addr_ev && addr_ack) begin
            ptr_r <= addr_c;
        end else if (tx_done || (data_ev && data_ack)) begin
            ptr_r <= ptr_r + AW'(1);
        end
    end

    // ****************************************************************
    // Page buffer and pending operation
    // ****************************************************************
    // The buffer holds the whole page so that nothing touches the array
    // before the stop; a repeated start into a read keeps the page pending, while an acknowledged write address clears it.
    logic [7:0] page_r [PAGE_BYTES];

    always_ff @(posedge mclk) begin
        if (data_ev && data_ack) begin
            page_r[cnt_r[CW-2:0]] <= sh_r;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rw_r <= 1'b0;
            hi_r <= 2'b00;
            er_sel_r <= 1'b0;
            er_go_r <= 1'b0;
            all_r <= 1'b0;
            trig_r <= 1'b0;
            refused_r <= 1'b0;
            cnt_r <= '0;
            base_r <= '0;
        end else if (launch) begin
            er_go_r <= 1'b0;
            er_sel_r <= 1'b0;
            cnt_r <= '0;
        end else if (dev_ev && dev_ack) begin
            rw_r <= sh_r[0];
            hi_r <= rx_sel[1:0] & SEL_MASK[1:0];
            if (!sh_r[0]) begin
                er_sel_r <= sec_ok || full_ok;
                er_go_r <= full_ok;
                all_r <= full_ok;
                trig_r <= 1'b0;
                refused_r <= 1'b0;
                cnt_r <= '0;
            end
        end else if (addr_ev) begin
            base_r <= addr_c;
            if (er_sel_r && addr_ack) begin
                er_go_r <= 1'b1;
            end
        end else if (data_ev) begin
            if (data_ack) begin
                cnt_r <= cnt_r + CW'(1);
                if (cnt_r == '0 && ERASE_MODE == IFS_ER_TRIG
                    && (ptr_r == AW'(TRIG0) || ptr_r == AW'(TRIG1))) begin
                    trig_r <= 1'b1;
                end
            end else if (cnt_r == '0) begin
                refused_r <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Flash sequencer and busy flag
    // ****************************************************************
    // Only one command is outstanding at a time; reads never collide with
    // it because the address is refused while busy.
    ifs_seq_t sq_r;
    logic [CW-1:0] idx_r, len_r;
    logic rd_vld_r;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sq_r <= IFS_SQ_IDLE;
            busy_r <= 1'b0;
            idx_r <= '0;
            len_r <= '0;
            flash_addr <= 10'h000;
            flash_wdata <= 8'h00;
            flash_rd <= 1'b0;
            flash_prog <= 1'b0;
            flash_erase <= 1'b0;
            flash_erase_all <= 1'b0;
            flash_sector <= 1'b0;
        end else begin
            flash_rd <= 1'b0;
            flash_prog <= 1'b0;
            flash_erase <= 1'b0;
            case (sq_r)
                IFS_SQ_IDLE: begin
                    if (launch) begin
                        busy_r <= 1'b1;
                        idx_r <= '0;
                        len_r <= cnt_r;
                        flash_erase_all <= all_r;
                        flash_sector <= base_r[AW-1];
                        if (ERASE_MODE != IFS_ER_NONE && (er_go_r || trig_r)) begin
                            sq_r <= IFS_SQ_ERASE;
                        end else begin
                            sq_r <= IFS_SQ_PROG;
                        end
                    end else if (dev_rd_ev || tx_done) begin
                        flash_rd <= 1'b1;
                        flash_addr <= 10'(dev_rd_ev ? ptr_r : AW'(ptr_r + AW'(1)));
                    end
                end
                IFS_SQ_ERASE: begin
                    flash_erase <= 1'b1;
                    sq_r <= IFS_SQ_EWAIT;
                end
                IFS_SQ_EWAIT: begin
                    if (flash_done) begin
                        sq_r <= (len_r != '0) ? IFS_SQ_PROG : IFS_SQ_IDLE;
                        busy_r <= (len_r != '0);
                    end
                end
                IFS_SQ_PROG: begin
                    flash_prog <= 1'b1;
                    flash_addr <= 10'(AW'(base_r + AW'(idx_r)));
                    flash_wdata <= page_r[idx_r[CW-2:0]];
                    sq_r <= IFS_SQ_PWAIT;
                end
                IFS_SQ_PWAIT: begin
                    if (flash_done) begin
                        idx_r <= idx_r + CW'(1);
                        if (idx_r + CW'(1) == len_r) begin
                            sq_r <= IFS_SQ_IDLE;
                            busy_r <= 1'b0;
                        end else begin
                            sq_r <= IFS_SQ_PROG;
                        end
                    end
                end
                default: begin
                    sq_r <= IFS_SQ_IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Read data capture
    // ****************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rd_vld_r <= 1'b0;
            tx_r <= 8'h00;
        end else begin
            rd_vld_r <= flash_rd;
            if (rd_vld_r) begin
                tx_r <= flash_rdata;
            end
        end
    end

    assign busy = busy_r;

endmodule

`default_nettype wire

// *** test/ifs_slave_monitor.sv ***
/*
 * Checker for the flash-backed serial slave, watching top-level ports.
 * Assumes the default full-erase build and the single mclk domain.
 */
`default_nettype none

module ifs_slave_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_oe_n,
    // Flash port and status
    input wire logic flash_rd,
    input wire logic flash_prog,
    input wire logic flash_erase,
    input wire logic flash_erase_all,
    input wire logic flash_done,
    input wire logic busy
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    AST_PROG_BUSY: assert property (flash_prog |-> busy)
        else $error("program pulse outside busy");
    AST_LAUNCH: assert property ($rose(busy) |=> flash_prog || flash_erase)
        else $error("no flash command after busy rose");
    AST_BUSY_STOP: assert property ($rose(busy) |-> scl_i && sda_i)
        else $error("busy rose without a stop on the bus");
    AST_BUSY_NACK: assert property (busy |-> sda_oe_n)
        else $error("slave drove data while busy");
    AST_BUSY_DONE: assert property ($fell(busy) |-> $past(flash_done))
        else $error("busy fell without flash completion");
    AST_PAGE_STEP: assert property (flash_done |-> ##2 (flash_prog || !busy))
        else $error("flash completion not followed by next byte or idle");
    AST_ERASE_ALL: assert property (flash_erase |-> flash_erase_all && busy)
        else $error("erase not of the whole array");
    AST_RD_IDLE: assert property (flash_rd |-> !busy)
        else $error("array read while busy");
    AST_ONE_STROBE: assert property ($onehot0({flash_rd, flash_prog, flash_erase}))
        else $error("two flash strobes at once");

    // Main scenarios are reached.
    COV_ERASE: cover property (flash_erase);
    COV_PROG: cover property (flash_prog ##1 !flash_prog);
    COV_DONE: cover property ($fell(busy));
endmodule

bind ifs_slave ifs_slave_monitor ifs_slave_monitor_i (.mclk, .arst_n, .scl_i, .sda_i, .sda_oe_n,
    .flash_rd, .flash_prog, .flash_erase, .flash_erase_all, .flash_done, .busy);

`default_nettype wire

// *** test/ifs_master.sv ***
/*
 * Bus master model driving the slave's clock and data pins.
 * Assumes a pull-up on data; slave only pulls low when its enable is low.
 */
`default_nettype none

module ifs_master (
    // Bus
    output logic scl,
    output logic sda,
    input wire logic sda_o,
    input wire logic sda_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sda_m = 1'b1;

    // ****************************************************************
    // Bit and byte tasks
    // ****************************************************************
    assign sda = sda_m & (sda_oe_n | sda_o);
    initial scl = 1'b1;

    task automatic bit_io(input logic b, output logic r);
        scl = 1'b0;
        #50 sda_m = b;
        #50 scl = 1'b1;
        #50 r = sda;
        #50;
    endtask

    task automatic start();
        scl = 1'b0;
        #50 sda_m = 1'b1;
        #50 scl = 1'b1;
        #50 sda_m = 1'b0;
        #50;
    endtask

    // Clock stays high after a stop, so the link stands still between frames.
    task automatic stop();
        scl = 1'b0;
        #50 sda_m = 1'b0;
        #50 scl = 1'b1;
        #50 sda_m = 1'b1;
        #300;
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask

    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(!ack, r);
    endtask
endmodule

`default_nettype wire

// *** test/ifs_slave_tb_top.sv ***
/*
 * Testbench of the flash-backed serial slave: master model, flash model
 * and a byte model of the array that every read is compared with.
 * Assumes the default build: 512 bytes, 16-byte page, full erase.
 */
`default_nettype none

module ifs_slave_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic wp = 1'b0;
    logic [2:0] dsel = 3'h0;
    logic scl, sda, sda_o, sda_oe_n, rd, prog, erase, all, sector, busy;
    logic done = 1'b0;
    logic [9:0] faddr;
    logic [7:0] wdata;
    logic [7:0] rdata = 8'h00;
    logic [7:0] fmem [512];
    int exp_mem [512];
    int errors = 0;
    int n_checks = 0;
    int lat = 0;
    int ptr;

    always #12.5 mclk = ~mclk;

    ifs_master m (.scl(scl), .sda(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
    ifs_slave ifs_slave_i (.mclk(mclk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .write_protect(wp), .device_select_bit_two(dsel[2]),
        .device_select_bit_one(dsel[1]), .device_select_bit_zero(dsel[0]), .flash_addr(faddr),
        .flash_wdata(wdata), .flash_rd(rd), .flash_prog(prog), .flash_erase(erase),
        .flash_erase_all(all), .flash_sector(sector), .flash_rdata(rdata),
        .flash_done(done), .busy(busy));

    // ****************************************************************
    // Flash array: program only clears bits, so a missing erase shows up.
    // ****************************************************************
    always @(posedge mclk) begin
        rdata <= rd ? fmem[faddr[8:0]] : 8'($urandom);
        done <= lat == 1;
        if (lat > 0) lat <= lat - 1;
        if (prog) fmem[faddr[8:0]] <= fmem[faddr[8:0]] & wdata;
        for (int i = 0; i < 512; i++) begin
            if (erase && (all || i[8] == sector)) fmem[i] <= 8'hFF;
        end
        if (prog || erase) lat <= 100 + $urandom % 100;
    end

    task automatic chk_byte(input string n, input int e, input logic [7:0] g);
        n_checks++;
        if (g !== 8'(e)) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, 8'(e), g);
        end
    endtask

    task automatic chk_ack(input string n, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic poll(output int n);
        logic a;
        n = 0;
        do begin
            m.start();
            m.wbyte(8'hA0, a);
            m.stop();
            n++;
        end while (a !== 1'b1 && n < 500);
        chk_ack("poll_ack", 1'b1, a);
    endtask

    task automatic wr(input logic [8:0] adr, input int cnt, input int nok);
        logic a;
        logic [7:0] d;
        m.start();
        m.wbyte({4'hA, 2'b00, adr[8], 1'b0}, a);
        chk_ack("wr_dev", 1'b1, a);
        m.wbyte(adr[7:0], a);
        chk_ack("wr_addr", 1'b1, a);
        for (int i = 0; i < cnt; i++) begin
            d = 8'($urandom);
            m.wbyte(d, a);
            chk_ack("wr_data", i < nok, a);
            if (i < nok) exp_mem[(adr + i) % 512] &= d;
        end
        m.stop();
    endtask

    task automatic rd_seq(input logic [8:0] adr, input int cnt, input logic rnd);
        logic a;
        logic [7:0] d;
        m.start();
        if (rnd) begin
            m.wbyte({4'hA, 2'b00, adr[8], 1'b0}, a);
            m.wbyte(adr[7:0], a);
            m.start();
        end
        m.wbyte({4'hA, 2'b00, adr[8], 1'b1}, a);
        chk_ack("rd_dev", 1'b1, a);
        for (int i = 0; i < cnt; i++) begin
            m.rbyte(i < cnt - 1, d);
            chk_byte("rd_data", exp_mem[(adr + i) % 512], d);
        end
        m.stop();
        ptr = (adr + cnt) % 512;
    endtask

    task automatic summarize();
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #2000000;
        errors++;
        summarize();
    end

    initial begin
        logic a;
        int n;
        void'($urandom(55143));
        foreach (fmem[i]) fmem[i] = 8'($urandom);
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(negedge mclk);
        m.start();
        m.wbyte(8'hAE, a);
        chk_ack("erase_dev", 1'b1, a);
        m.stop();
        foreach (exp_mem[i]) exp_mem[i] = 255;
        poll(n);
        chk_ack("erase_poll", 1'b1, n > 1);
        wr(9'h010, 17, 16);
        poll(n);
        chk_ack("page_poll", 1'b1, n > 1);
        rd_seq(9'h010, 4, 1'b1);
        rd_seq(9'(ptr), 13, 1'b0);
        @(posedge mclk);
        wp <= 1'b1;
        repeat (4) @(negedge mclk);
        wr(9'h100, 1, 0);
        poll(n);
        chk_ack("wp_idle", 1'b1, n == 1);
        m.start();
        m.wbyte(8'hAE, a);
        chk_ack("wp_erase", 1'b0, a);
        m.stop();
        wr(9'h030, 1, 1);
        poll(n);
        rd_seq(9'h030, 1, 1'b1);
        rd_seq(9'h0FF, 2, 1'b1);
        summarize();
    end
endmodule

`default_nettype wire
